// [rtl/imuo_pkg.sv]
// package for the inertial output data registers: offsets, layouts, codes
// assumes a 16-bit register read port addressed by byte address
package imuo_pkg;

  localparam int unsigned ADDR_W = 7;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned AXIS_W = 32;

  // byte addresses of the even byte of each register word
  localparam logic [6:0] OFS_RATE_Y_LOW   = 7'h08;
  localparam logic [6:0] OFS_RATE_Y_HIGH  = 7'h0a;
  localparam logic [6:0] OFS_RATE_Z_LOW   = 7'h0c;
  localparam logic [6:0] OFS_RATE_Z_HIGH  = 7'h0e;
  localparam logic [6:0] OFS_ACCEL_X_LOW  = 7'h10;
  localparam logic [6:0] OFS_ACCEL_X_HIGH = 7'h12;
  localparam logic [6:0] OFS_ACCEL_Y_LOW  = 7'h14;
  localparam logic [6:0] OFS_ACCEL_Y_HIGH = 7'h16;
  localparam logic [6:0] OFS_ACCEL_Z_LOW  = 7'h18;
  localparam logic [6:0] OFS_ACCEL_Z_HIGH = 7'h1a;

  // 32-bit axis layout: high word upper half, low word lower half
  localparam int unsigned HIGH_MSB = 31;
  localparam int unsigned HIGH_LSB = 16;
  localparam int unsigned LOW_MSB  = 15;
  localparam int unsigned LOW_LSB  = 0;

  // values after reset and for unmapped reads
  localparam logic [15:0] WORD_RESET    = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;

  // gyro range codes and scale factors in counts per degree per second
  localparam logic [1:0] RANGE_125  = 2'h0;
  localparam logic [1:0] RANGE_500  = 2'h1;
  localparam logic [1:0] RANGE_2000 = 2'h2;
  localparam logic [7:0] SCALE_125  = 8'ha0;
  localparam logic [7:0] SCALE_500  = 8'h28;
  localparam logic [7:0] SCALE_2000 = 8'h0a;
  localparam logic [7:0] SCALE_RESET = 8'h00;

  // read port answer state, one-hot
  typedef enum logic [1:0] {
    RD_IDLE   = 2'b01,
    RD_ANSWER = 2'b10
  } imuo_rd_state_type;

  typedef struct packed {
    logic [15:0] high;
    logic [15:0] low;
  } imuo_axis_type;

  typedef struct packed {
    logic        valid;
    logic [31:0] rate_y;
    logic [31:0] rate_z;
    logic [31:0] accel_x;
    logic [31:0] accel_y;
    logic [31:0] accel_z;
  } imuo_sample_type;

  typedef struct packed {
    logic        rd_req;
    logic        wr_req;
    logic [6:0]  addr;
    logic [15:0] wr_data;
  } imuo_req_type;

  // word address of a byte address; both bytes of a word map together
  function automatic logic [5:0] imuo_word(input logic [6:0] byte_addr);
    imuo_word = byte_addr[6:1];
  endfunction

endpackage

// [rtl/imuo_axis_word.sv]
// one axis result held as a high and a low register word
// assumes load is a one-cycle pulse carrying a fresh 32-bit sample
`timescale 1ns/1ps
`default_nettype none
module imuo_axis_word
  import imuo_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                load,
  input  wire logic [31:0]         sample,
  output var  imuo_pkg::imuo_axis_type axis_q
);

  imuo_axis_type axis_d;

  always_comb
  begin
    axis_d = axis_q;
    if (load)
    begin
      axis_d.high = sample[HIGH_MSB:HIGH_LSB];
      axis_d.low  = sample[LOW_MSB:LOW_LSB];
    end
  end

  // both halves load in the same edge so a pair always belongs to one sample
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      axis_q.high <= WORD_RESET;
      axis_q.low  <= WORD_RESET;
    end
    else
    begin
      axis_q <= axis_d;
    end
  end

endmodule
`default_nettype wire

// [rtl/imuo_gyro_scale.sv]
// gyro scale factor of the fitted range variant
// assumes range_sel is static in use; it is sampled every clock
`timescale 1ns/1ps
`default_nettype none
module imuo_gyro_scale
  import imuo_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [1:0] range_sel,
  output logic      [7:0] scale_q
);

  logic [7:0] scale_d;

  always_comb
  begin
    case (range_sel)
      RANGE_125:  scale_d = SCALE_125;
      RANGE_500:  scale_d = SCALE_500;
      RANGE_2000: scale_d = SCALE_2000;
      // unused code falls back to the widest range
      default:    scale_d = SCALE_2000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      scale_q <= SCALE_RESET;
    else
      scale_q <= scale_d;
  end

endmodule
`default_nettype wire

// [rtl/imuo_data_regs.sv]
// output data registers for y/z rate and x/y/z acceleration
// assumes a serial front end that issues 16-bit register reads by byte address
// What this block does
// - rate_y_low_word at 0x08/0x09 is a read-only word of extra y-rate resolution bits.
// - rate_y_high_word at 0x0a/0x0b is the two's-complement y rate, zero rate reading 0x0000.
// - rate_z_low_word at 0x0c/0x0d is a read-only word of extra z-rate resolution bits.
// - rate_z_high_word at 0x0e/0x0f is the two's-complement z rate, zero rate reading 0x0000.
// - each acceleration axis is one 32-bit value, high word on top and low word below.
// - accel_x_low_word at 0x10/0x11 is a read-only word of extra x-acceleration bits.
// - accel_x_high_word at 0x12/0x13 is two's-complement x acceleration, 1.25 mg a count.
// - accel_y_low_word at 0x14/0x15 is a read-only word of extra y-acceleration bits.
// - accel_y_high_word at 0x16/0x17 is two's-complement y acceleration, 1.25 mg a count.
// - accel_z_low_word at 0x18/0x19 is a read-only word of extra z-acceleration bits.
// - accel_z_high_word at 0x1a/0x1b is two's-complement z acceleration over 40 g.
// - the gyro scale factor is 160, 40 or 10 counts per deg/s for the three ranges.
`timescale 1ns/1ps
`default_nettype none
module imuo_data_regs
  import imuo_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire imuo_pkg::imuo_sample_type sample_in,
  input  wire logic [1:0]              gyro_range,
  input  wire imuo_pkg::imuo_req_type  req_in,
  output logic [15:0]                  rd_data_q,
  output logic                         rd_valid,
  output logic                         rd_unmapped_q,
  output logic                         wr_ignored_q,
  output logic                         sample_ready_q,
  output logic [7:0]                   gyro_scale
);

  imuo_axis_type     rate_y;
  imuo_axis_type     rate_z;
  imuo_axis_type     accel_x;
  imuo_axis_type     accel_y;
  imuo_axis_type     accel_z;
  imuo_rd_state_type state_q;
  imuo_rd_state_type state_d;
  logic [15:0]       rd_data_d;
  logic              rd_unmapped_d;
  logic [5:0]        word_idx;

  // all five axes take the same strobe so a burst of reads sees one sample
  imuo_axis_word u_rate_y
  (
    .clk    (clk),
    .rstn   (rstn),
    .load   (sample_in.valid),
    .sample (sample_in.rate_y),
    .axis_q (rate_y)
  );

  imuo_axis_word u_rate_z
  (
    .clk    (clk),
    .rstn   (rstn),
    .load   (sample_in.valid),
    .sample (sample_in.rate_z),
    .axis_q (rate_z)
  );

  imuo_axis_word u_accel_x
  (
    .clk    (clk),
    .rstn   (rstn),
    .load   (sample_in.valid),
    .sample (sample_in.accel_x),
    .axis_q (accel_x)
  );

  imuo_axis_word u_accel_y
  (
    .clk    (clk),
    .rstn   (rstn),
    .load   (sample_in.valid),
    .sample (sample_in.accel_y),
    .axis_q (accel_y)
  );

  imuo_axis_word u_accel_z
  (
    .clk    (clk),
    .rstn   (rstn),
    .load   (sample_in.valid),
    .sample (sample_in.accel_z),
    .axis_q (accel_z)
  );

  imuo_gyro_scale u_gyro_scale
  (
    .clk       (clk),
    .rstn      (rstn),
    .range_sel (gyro_range),
    .scale_q   (gyro_scale)
  );

  assign word_idx = imuo_word(req_in.addr);

  // read decode; either byte address of a pair selects the whole word
  always_comb
  begin
    rd_data_d     = UNMAPPED_READ;
    rd_unmapped_d = 1'b0;
    case (word_idx)
      imuo_word(OFS_RATE_Y_LOW):   rd_data_d = rate_y.low;
      imuo_word(OFS_RATE_Y_HIGH):  rd_data_d = rate_y.high;
      imuo_word(OFS_RATE_Z_LOW):   rd_data_d = rate_z.low;
      imuo_word(OFS_RATE_Z_HIGH):  rd_data_d = rate_z.high;
      imuo_word(OFS_ACCEL_X_LOW):  rd_data_d = accel_x.low;
      imuo_word(OFS_ACCEL_X_HIGH): rd_data_d = accel_x.high;
      imuo_word(OFS_ACCEL_Y_LOW):  rd_data_d = accel_y.low;
      imuo_word(OFS_ACCEL_Y_HIGH): rd_data_d = accel_y.high;
      imuo_word(OFS_ACCEL_Z_LOW):  rd_data_d = accel_z.low;
      imuo_word(OFS_ACCEL_Z_HIGH): rd_data_d = accel_z.high;
      default:                     rd_unmapped_d = 1'b1;
    endcase
  end

  always_comb
  begin
    case (state_q)
      RD_IDLE:   state_d = req_in.rd_req ? RD_ANSWER : RD_IDLE;
      RD_ANSWER: state_d = req_in.rd_req ? RD_ANSWER : RD_IDLE;
      default:   state_d = RD_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      state_q <= RD_IDLE;
    else
      state_q <= state_d;
  end

  assign rd_valid = (state_q == RD_ANSWER);

  // read data is captured only on a read; no register state moves with it
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rd_data_q     <= WORD_RESET;
      rd_unmapped_q <= 1'b0;
    end
    else if (req_in.rd_req)
    begin
      rd_data_q     <= rd_data_d;
      rd_unmapped_q <= rd_unmapped_d;
    end
  end

  // writes never reach the data words; they only raise a one-cycle notice
  always_ff @(posedge clk)
  begin
    if (!rstn)
      wr_ignored_q <= 1'b0;
    else
      wr_ignored_q <= req_in.wr_req;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      sample_ready_q <= 1'b0;
    else
      sample_ready_q <= sample_in.valid;
  end

endmodule
`default_nettype wire

// [bench/imuo_data_regs_props.sv]
// assertions on the ports of the output data register block
// assumes clk rising edge and synchronous active-low rstn
`timescale 1ns/1ps
`default_nettype none
module imuo_data_regs_props
  import imuo_pkg::*;
(
  input wire logic                      clk,
  input wire logic                      rstn,
  input wire imuo_pkg::imuo_sample_type sample_in,
  input wire logic [1:0]                gyro_range,
  input wire imuo_pkg::imuo_req_type    req_in,
  input wire logic [15:0]               rd_data_q,
  input wire logic                      rd_valid,
  input wire logic                      rd_unmapped_q,
  input wire logic                      wr_ignored_q,
  input wire logic                      sample_ready_q,
  input wire logic [7:0]                gyro_scale
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // shadow of the last sample; reads at the load edge still see the old one
  imuo_sample_type smp_q;
  always_ff @(posedge clk)
    if (!rstn)
      smp_q <= '0;
    else if (sample_in.valid)
      smp_q <= sample_in;
  wire [159:0] flat = {smp_q.accel_z, smp_q.accel_y, smp_q.accel_x, smp_q.rate_z, smp_q.rate_y};
  wire [5:0]   wi   = req_in.addr[6:1];
  wire         mapd = wi >= 6'h04 && wi <= 6'h0d;
  wire [15:0]  ew   = mapd ? flat[(int'(wi) - 4) * 16 +: 16] : 16'h0000;
  wire [7:0]   es   = gyro_range == RANGE_125 ? SCALE_125 :
                      gyro_range == RANGE_500 ? SCALE_500 : SCALE_2000;
  sequence s_rd;
    req_in.rd_req;
  endsequence
  sequence s_word;
    rd_valid && !rd_unmapped_q && rd_data_q == $past(ew);
  endsequence
  a_rd_answer: assert property (s_rd |=> rd_valid)
    else $error("read not answered");
  a_rd_quiet: assert property (!req_in.rd_req |=> !rd_valid && $stable(rd_data_q))
    else $error("answer without read");
  a_rate_word: assert property (s_rd ##0 (mapd && wi <= 6'h07) |=> s_word)
    else $error("rate word wrong");
  a_accel_word: assert property (s_rd ##0 (wi >= 6'h08 && mapd) |=> s_word)
    else $error("accel word wrong");
  a_unmapped_read: assert property (s_rd ##0 !mapd |=> rd_unmapped_q && rd_data_q == 16'h0000)
    else $error("unmapped read wrong");
  a_wr_pulse: assert property (1'b1 |=> wr_ignored_q == $past(req_in.wr_req))
    else $error("write pulse wrong");
  a_load_pulse: assert property (1'b1 |=> sample_ready_q == $past(sample_in.valid))
    else $error("load pulse wrong");
  a_gyro_scale: assert property (rstn |=> gyro_scale == $past(es))
    else $error("scale wrong");
endmodule
bind imuo_data_regs imuo_data_regs_props u_props (.clk, .rstn, .sample_in, .gyro_range,
  .req_in, .rd_data_q, .rd_valid, .rd_unmapped_q, .wr_ignored_q, .sample_ready_q, .gyro_scale);
`default_nettype wire

// [bench/imuo_host_model.sv]
// host model of the register port, standing for the serial front end
// assumes the caller waits for reset release before the first request
`timescale 1ns/1ps
`default_nettype none
module imuo_host_model
  import imuo_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic [15:0]            rd_data_q,
  input  wire logic                   rd_valid,
  input  wire logic                   rd_unmapped_q,
  output var  imuo_pkg::imuo_req_type req
);
  initial req = '0;
  // one-cycle request; lines then go to the inverse so stale values never match
  task automatic rd(input logic [6:0] a, output logic [15:0] d, output logic u, output logic v);
    @(posedge clk);
    req.rd_req <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd_req <= 1'b0;
    req.addr <= ~a;
    #1;
    d = rd_data_q;
    u = rd_unmapped_q;
    v = rd_valid;
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] w);
    @(posedge clk);
    req.wr_req <= 1'b1;
    req.addr <= a;
    req.wr_data <= w;
    @(posedge clk);
    req.wr_req <= 1'b0;
    req.addr <= ~a;
    req.wr_data <= ~w;
  endtask
endmodule
`default_nettype wire

// [bench/imuo_data_regs_tb.sv]
// self-checking bench for the output data register block
// assumes the host model owns the request port and the bench the samples
`timescale 1ns/1ps
`default_nettype none
module imuo_data_regs_tb;
  import imuo_pkg::*;
  logic            clk = 1'b0;
  logic            rstn = 1'b0;
  imuo_sample_type sample_in = '0;
  logic [1:0]      gyro_range = 2'h0;
  imuo_req_type    req_in;
  logic [15:0]     rd_data_q, lo, hi;
  logic            rd_valid, rd_unmapped_q, wr_ignored_q, sample_ready_q, u, v;
  logic [7:0]      gyro_scale;
  int              n_fail = 0;
  int              total_checks = 0;
  logic [31:0]     ax [5] = '{32'h4e200000, 32'hb1e00001, 32'h7d000000, 32'h83000000, 32'hfffffffe};
  logic [6:0]      um [3] = '{7'h07, 7'h1c, 7'h7f};
  logic [7:0]      sc [4] = '{8'ha0, 8'h28, 8'h0a, 8'h0a};
  always #5 clk = ~clk;
  imuo_data_regs dut (.clk, .rstn, .sample_in, .gyro_range, .req_in, .rd_data_q, .rd_valid,
    .rd_unmapped_q, .wr_ignored_q, .sample_ready_q, .gyro_scale);
  imuo_host_model host (.clk, .rd_data_q, .rd_valid, .rd_unmapped_q, .req(req_in));
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // low word through its odd byte, high word through its even byte
  task automatic rd_axis(input int k, input logic [31:0] e);
    host.rd(7'(9 + 4 * k), lo, u, v);
    host.rd(7'(10 + 4 * k), hi, u, v);
    chk({u, v, hi, lo}, {2'b01, e});
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    for (int k = 0; k < 5; k++)
      rd_axis(k, 32'h0);
    $display("test reset_values done");
    @(posedge clk);
    sample_in <= {1'b1, ax[0], ax[1], ax[2], ax[3], ax[4]};
    @(posedge clk);
    sample_in.valid <= 1'b0;
    #1;
    chk(sample_ready_q, 1'b1);
    for (int k = 0; k < 5; k++)
      rd_axis(k, ax[k]);
    $display("test extremes done");
    for (int i = 0; i < 10; i++)
    begin
      host.wr(7'(8 + 2 * i), 16'h5a5a);
      #1;
      chk(wr_ignored_q, 1'b1);
    end
    for (int k = 0; k < 5; k++)
      rd_axis(k, ax[k]);
    foreach (um[i])
    begin
      host.rd(um[i], lo, u, v);
      chk({u, v, lo}, 18'h30000);
    end
    $display("test writes_unmapped done");
    for (int r = 0; r < 4; r++)
    begin
      @(posedge clk);
      gyro_range <= 2'(r);
      repeat (2) @(posedge clk);
      #1;
      chk(gyro_scale, sc[r]);
    end
    $display("test scale done");
    // inverted extremes leave no low word at zero, so a stuck low word shows
    @(posedge clk);
    sample_in <= {1'b1, ~ax[0], ~ax[1], ~ax[2], ~ax[3], ~ax[4]};
    @(posedge clk);
    sample_in.valid <= 1'b0;
    for (int k = 0; k < 5; k++)
      rd_axis(k, ~ax[k]);
    $display("test low_words done");
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk(gyro_scale, SCALE_RESET);
    for (int k = 0; k < 5; k++)
      rd_axis(k, 32'h0);
    chk(gyro_scale, sc[3]);
    $display("test mid_reset done");
    give_verdict();
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
endmodule
`default_nettype wire
